// [include/rxcl_pkg.sv]
package rxcl_pkg;

  // *****************************************************
  // Register map (byte addresses on a 32-bit AXI4-Lite bus)
  // *****************************************************
  localparam int          ADDR_W      = 8;
  localparam logic [7:0]  ADDR_CTRL   = 8'h00;
  localparam logic [7:0]  ADDR_SLIP   = 8'h04;
  localparam logic [7:0]  ADDR_THRESH = 8'h08;
  localparam logic [7:0]  ADDR_STATUS = 8'h0C;

  // Control register fields and reset value.
  localparam int          CTRL_LTD     = 0;
  localparam int          CTRL_LOCK_REF = 1;
  localparam int          CTRL_MANUAL  = 2;
  localparam int          CTRL_ETH     = 3;
  localparam int          CTRL_BASIC   = 4;
  localparam int          CTRL_PIPE    = 5;
  localparam int          CTRL_USE_CLK = 6;
  localparam int          CTRL_W       = 7;
  localparam logic [6:0]  CTRL_RST     = 7'h00;
  localparam logic [7:0]  THRESH_RST   = 8'h04;

  // Status register fields.
  localparam int          ST_LOCKED = 0;
  localparam int          ST_SIGDET = 1;
  localparam int          ST_FIFOER = 2;
  localparam int          ST_SLIP   = 4;
  localparam int          ST_MODE   = 8;

  // Bus responses.
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // Word aligner.
  localparam int          WORD_W   = 10;
  localparam logic [3:0]  SLIP_LAST = 4'h9;
  localparam logic [3:0]  HALF_BIT = 4'h4;

  // Timing.
  localparam int          CLK_PERIOD_PS = 4000;
  localparam int          LOCK_WAIT_NS  = 1000;
  localparam int          LOCK_WAIT_CYC =
    (LOCK_WAIT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int          SD_WIN_CYC    = 64;
  localparam int          FIFO_AW_DEF   = 3;

  // Recovery lock modes, priority-encoded from the two lock controls.
  typedef enum logic [1:0]
  {
    RXCL_MODE_AUTO    = 2'b00,
    RXCL_MODE_MAN_REF = 2'b01,
    RXCL_MODE_MAN_LTD = 2'b10
  } rxcl_mode_e;

  // Recovery lock state.
  typedef enum logic [1:0]
  {
    RXCL_ST_REF = 2'b00,
    RXCL_ST_LTD = 2'b01
  } rxcl_state_e;

endpackage

// [include/rxcl_lock_if.sv]
`timescale 1ns/100ps

// Lock controls toward the recovery logic and its state back.
interface rxcl_lock_if;
  logic              lock_to_data;
  logic              locked_to_reference;
  logic              sig_present;
  logic              ltd;
  logic [1:0]        mode;

  modport ctl
  (
    output lock_to_data,
    output locked_to_reference,
    output sig_present,
    input  ltd,
    input  mode
  );

  modport cdr
  (
    input  lock_to_data,
    input  locked_to_reference,
    input  sig_present,
    output ltd,
    output mode
  );
endinterface

// [hw/rxcl_mem.sv]
`timescale 1ns/100ps

// Storage of the phase compensation FIFO with registered read data.
module rxcl_mem #(
  parameter int W  = 10,
  parameter int AW = 3
) (
  input  wire logic          clk_sys_i,
  input  wire logic          we_i,
  input  wire logic [AW-1:0] waddr_i,
  input  wire logic [W-1:0]  wdata_i,
  input  wire logic          re_i,
  input  wire logic [AW-1:0] raddr_i,
  output logic      [W-1:0]  rdata_o
);

  logic [W-1:0] mem_reg [0:(1<<AW)-1];

  if (AW < 1 || W < 1)
  begin : g_chk
    $error("rxcl_mem: width and address width must be positive.");
  end

  // Write and read ports; memory content needs no reset.
  always_ff @(posedge clk_sys_i)
  begin
    if (we_i)
    begin
      mem_reg[waddr_i] <= wdata_i;
    end
    if (re_i)
    begin
      rdata_o <= mem_reg[raddr_i];
    end
  end
endmodule

// [hw/rxcl_cdr_lock.sv]
`timescale 1ns/100ps

// Clock recovery lock controller.
module rxcl_cdr_lock
  import rxcl_pkg::*;
#(
  parameter int WAIT = LOCK_WAIT_CYC
) (
  input  wire logic clk_sys_i,
  input  wire logic rst_i,
  rxcl_lock_if.cdr  lk
);

  localparam int CW = $clog2(WAIT + 1);

  rxcl_state_e    state_reg;
  rxcl_state_e    state_next;
  rxcl_mode_e     mode_w;
  logic [CW-1:0]  wait_reg;
  logic           wait_done;

  if (WAIT < 1)
  begin : g_chk
    $error("rxcl_cdr_lock: lock wait must be at least one cycle.");
  end

  // Lock-to-data wins over lock-to-reference.
  assign mode_w = lk.lock_to_data ? RXCL_MODE_MAN_LTD :
                  lk.locked_to_reference ? RXCL_MODE_MAN_REF :
                  RXCL_MODE_AUTO;
  assign wait_done = (wait_reg == CW'(WAIT));
  assign lk.ltd    = (state_reg == RXCL_ST_LTD);
  assign lk.mode   = mode_w;

  // Next lock state per mode.
  always_comb
  begin
    state_next = state_reg;
    case (mode_w)
      RXCL_MODE_MAN_LTD: state_next = RXCL_ST_LTD;
      RXCL_MODE_MAN_REF: state_next = RXCL_ST_REF;
      RXCL_MODE_AUTO:
      begin
        if (!lk.sig_present)
        begin
          state_next = RXCL_ST_REF;
        end
        else if (wait_done)
        begin
          state_next = RXCL_ST_LTD;
        end
      end
      default: state_next = RXCL_ST_REF;
    endcase
  end

  // State and settle counter; the counter runs only in automatic mode.
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state_reg <= RXCL_ST_REF;
      wait_reg  <= '0;
    end
    else
    begin
      state_reg <= state_next;
      if (mode_w != RXCL_MODE_AUTO || !lk.sig_present)
        wait_reg <= '0;
      else if (!wait_done)
        wait_reg <= wait_reg + CW'(1);
    end
  end

  // ***********************************************
  // Checks
  // ***********************************************
  AST_FORCE_LTD: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    lk.lock_to_data |=> state_reg == RXCL_ST_LTD)
    else $error("Lock-to-data did not force the locked-to-data state.");
  AST_MAN_REF: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (!lk.lock_to_data && lk.locked_to_reference) |=> !lk.ltd)
    else $error("Manual reference lock did not hold reference state.");
  AST_AUTO_LOSS: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (mode_w == RXCL_MODE_AUTO && !lk.sig_present) |=> !lk.ltd)
    else $error("Automatic mode kept data lock without a signal.");
endmodule

// [hw/rxcl_top.sv]
// Design decisions made here: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/100ps

module rxcl_top
  import rxcl_pkg::*;
#(
  parameter int FIFO_AW = FIFO_AW_DEF,
  parameter int SD_WIN  = SD_WIN_CYC
) (
  // Clock and reset.
  input  wire logic              clk_sys_i,
  input  wire logic              rst_i,
  // Link and fabric pins.
  input  wire logic              rx_serial_i,
  input  wire logic              rx_coreclk_i,
  // Status toward the fabric.
  output logic                   freq_locked_o,
  output logic                   signal_detect_o,
  output logic [3:0]             slip_count_out_o,
  output logic                   fifo_error_o,
  output logic                   rec_clk_o,
  output logic [WORD_W-1:0]      rx_word_o,
  output logic                   rx_word_valid_o,
  // AXI4-Lite slave.
  input  wire logic [ADDR_W-1:0] s_axi_awaddr_i,
  input  wire logic              s_axi_awvalid_i,
  output logic                   s_axi_awready_o,
  input  wire logic [31:0]       s_axi_wdata_i,
  input  wire logic [3:0]        s_axi_wstrb_i,
  input  wire logic              s_axi_wvalid_i,
  output logic                   s_axi_wready_o,
  output logic [1:0]             s_axi_bresp_o,
  output logic                   s_axi_bvalid_o,
  input  wire logic              s_axi_bready_i,
  input  wire logic [ADDR_W-1:0] s_axi_araddr_i,
  input  wire logic              s_axi_arvalid_i,
  output logic                   s_axi_arready_o,
  output logic [31:0]            s_axi_rdata_o,
  output logic [1:0]             s_axi_rresp_o,
  output logic                   s_axi_rvalid_o,
  input  wire logic              s_axi_rready_i
);

  localparam int PW = FIFO_AW + 1;
  localparam int SW = $clog2(SD_WIN);

  if (FIFO_AW < 1 || SD_WIN < 2)
  begin : g_chk
    $error("rxcl_top: FIFO depth or detect window too small.");
  end

  // Register decode shared by the read and write paths: {hit, index}.
  function automatic logic [2:0] reg_dec(input logic [ADDR_W-1:0] a);
    case (a)
      ADDR_CTRL:   reg_dec = 3'b100;
      ADDR_SLIP:   reg_dec = 3'b101;
      ADDR_THRESH: reg_dec = 3'b110;
      ADDR_STATUS: reg_dec = 3'b111;
      default:     reg_dec = 3'b000;
    endcase
  endfunction

  // *****************************************************
  // Pin synchronisers
  // *****************************************************
  logic [1:0] pin_raw;
  logic [1:0] pin_ok;

  assign pin_raw = {rx_coreclk_i, rx_serial_i};

  // Three stages; the level moves on once stages two and three agree.
  for (genvar g = 0; g < 2; g++)
  begin : g_sync
    logic s1_reg;
    logic s2_reg;
    logic s3_reg;
    logic ok_reg;
    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
      if (rst_i)
      begin
        s1_reg <= 1'b0;
        s2_reg <= 1'b0;
        s3_reg <= 1'b0;
        ok_reg <= 1'b0;
      end
      else
      begin
        s1_reg <= pin_raw[g];
        s2_reg <= s1_reg;
        s3_reg <= s2_reg;
        if (s2_reg == s3_reg)
          ok_reg <= s3_reg;
      end
    end
    assign pin_ok[g] = ok_reg;
  end

  // *****************************************************
  // Registers and bus slave
  // *****************************************************
  logic [CTRL_W-1:0] ctrl_reg;
  logic [7:0]        thresh_reg;
  logic              slip_pulse_reg;
  logic              aw_hold_reg;
  logic              w_hold_reg;
  logic [ADDR_W-1:0] awaddr_reg;
  logic [31:0]       wdata_reg;
  logic [3:0]        wstrb_reg;
  logic [2:0]        wdec;
  logic [2:0]        rdec;
  logic              do_write;
  logic              aw_take;
  logic              w_take;
  logic              ar_take;
  logic [31:0]       status_w;
  logic [31:0]       rd_mux;
  logic [3:0]        slip_cnt_reg;
  rxcl_lock_if       lk ();

  assign aw_take  = s_axi_awvalid_i && s_axi_awready_o;
  assign w_take   = s_axi_wvalid_i && s_axi_wready_o;
  assign ar_take  = s_axi_arvalid_i && s_axi_arready_o;
  assign do_write = aw_hold_reg && w_hold_reg && !s_axi_bvalid_o;
  assign wdec     = reg_dec(awaddr_reg);
  assign rdec     = reg_dec(s_axi_araddr_i);

  // Status view and read selection.
  assign status_w = {22'h00_0000, lk.mode, slip_cnt_reg, 1'b0,
                     fifo_error_o, signal_detect_o, freq_locked_o};
  assign rd_mux   = (rdec[1:0] == 2'd0) ? {25'h000_0000, ctrl_reg} :
                    (rdec[1:0] == 2'd2) ? {24'h00_0000, thresh_reg} :
                    (rdec[1:0] == 2'd3) ? status_w : 32'h0000_0000;

  // Write channel: address and data in either order, then a response.
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      s_axi_awready_o <= 1'b1;
      s_axi_wready_o  <= 1'b1;
      s_axi_bvalid_o  <= 1'b0;
      s_axi_bresp_o   <= RESP_OKAY;
      aw_hold_reg     <= 1'b0;
      w_hold_reg      <= 1'b0;
      awaddr_reg      <= '0;
      wdata_reg       <= 32'h0000_0000;
      wstrb_reg       <= 4'h0;
    end
    else
    begin
      if (aw_take)
      begin
        aw_hold_reg     <= 1'b1;
        awaddr_reg      <= s_axi_awaddr_i;
        s_axi_awready_o <= 1'b0;
      end
      if (w_take)
      begin
        w_hold_reg     <= 1'b1;
        wdata_reg      <= s_axi_wdata_i;
        wstrb_reg      <= s_axi_wstrb_i;
        s_axi_wready_o <= 1'b0;
      end
      if (do_write)
      begin
        aw_hold_reg    <= 1'b0;
        w_hold_reg     <= 1'b0;
        s_axi_bvalid_o <= 1'b1;
        s_axi_bresp_o  <= wdec[2] ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_bvalid_o && s_axi_bready_i)
      begin
        s_axi_bvalid_o  <= 1'b0;
        s_axi_awready_o <= 1'b1;
        s_axi_wready_o  <= 1'b1;
      end
    end
  end

  // Register contents; the slip register only launches a pulse.
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      ctrl_reg       <= CTRL_RST;
      thresh_reg     <= THRESH_RST;
      slip_pulse_reg <= 1'b0;
    end
    else
    begin
      slip_pulse_reg <= do_write && wdec == 3'b101 && wstrb_reg[0] &&
                        wdata_reg[0];
      if (do_write && wdec == 3'b100 && wstrb_reg[0])
        ctrl_reg <= wdata_reg[CTRL_W-1:0];
      if (do_write && wdec == 3'b110 && wstrb_reg[0])
        thresh_reg <= wdata_reg[7:0];
    end
  end

  // Read channel: one read at a time, unmapped reads answer an error.
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      s_axi_arready_o <= 1'b1;
      s_axi_rvalid_o  <= 1'b0;
      s_axi_rdata_o   <= 32'h0000_0000;
      s_axi_rresp_o   <= RESP_OKAY;
    end
    else if (ar_take)
    begin
      s_axi_arready_o <= 1'b0;
      s_axi_rvalid_o  <= 1'b1;
      s_axi_rdata_o   <= rdec[2] ? rd_mux : 32'h0000_0000;
      s_axi_rresp_o   <= rdec[2] ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_rvalid_o && s_axi_rready_i)
    begin
      s_axi_rvalid_o  <= 1'b0;
      s_axi_arready_o <= 1'b1;
    end
  end

  // *****************************************************
  // Signal detect and lock control
  // *****************************************************
  logic          ser_prev_reg;
  logic [SW-1:0] win_reg;
  logic [7:0]    trans_reg;
  logic          sd_raw_reg;
  logic          sd_allowed;

  assign sd_allowed = ctrl_reg[CTRL_BASIC] || ctrl_reg[CTRL_PIPE];
  assign lk.lock_to_data        = ctrl_reg[CTRL_LTD];
  assign lk.locked_to_reference = ctrl_reg[CTRL_LOCK_REF];
  assign lk.sig_present         = sd_raw_reg;

  // Count line transitions per window and compare with the threshold.
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      ser_prev_reg <= 1'b0;
      win_reg      <= '0;
      trans_reg    <= 8'h00;
      sd_raw_reg   <= 1'b0;
    end
    else
    begin
      ser_prev_reg <= pin_ok[0];
      win_reg      <= win_reg + SW'(1);
      if (win_reg == SW'(SD_WIN - 1))
      begin
        sd_raw_reg <= (trans_reg > thresh_reg);
        trans_reg  <= 8'h00;
      end
      else if (pin_ok[0] != ser_prev_reg && trans_reg != 8'hFF)
        trans_reg <= trans_reg + 8'h01;
    end
  end

  rxcl_cdr_lock u_cdr_lock
  (
    .clk_sys_i (clk_sys_i),
    .rst_i     (rst_i),
    .lk        (lk.cdr)
  );

  // *****************************************************
  // Word aligner and phase compensation FIFO
  // *****************************************************
  logic [3:0]        bit_cnt_reg;
  logic [WORD_W-1:0] shift_reg;
  logic              slip_now;
  logic              word_done;
  logic [PW-1:0]     wptr_reg;
  logic [PW-1:0]     rptr_reg;
  logic              clk_prev_reg;
  logic              rd_stb;
  logic              fifo_full;
  logic              fifo_empty;
  logic              push;
  logic              pop;
  logic              pop_reg;
  logic [WORD_W-1:0] mem_rdata;

  assign slip_now   = slip_pulse_reg && ctrl_reg[CTRL_MANUAL];
  assign word_done  = !slip_now && bit_cnt_reg == SLIP_LAST;
  assign fifo_empty = (wptr_reg == rptr_reg);
  assign fifo_full  = (wptr_reg == (rptr_reg ^ {1'b1, {FIFO_AW{1'b0}}}));
  assign push       = word_done && lk.ltd && !fifo_full;
  assign rd_stb     = ctrl_reg[CTRL_USE_CLK] ?
                      (pin_ok[1] && !clk_prev_reg) : 1'b1;
  assign pop        = rd_stb && !fifo_empty;

  // Shift serial bits; a slip drops one bit and bumps the count.
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      bit_cnt_reg  <= 4'h0;
      shift_reg    <= '0;
      slip_cnt_reg <= 4'h0;
    end
    else if (slip_now)
      slip_cnt_reg <= (slip_cnt_reg == SLIP_LAST) ? 4'h0 :
                      slip_cnt_reg + 4'h1;
    else
    begin
      shift_reg   <= {pin_ok[0], shift_reg[WORD_W-1:1]};
      bit_cnt_reg <= word_done ? 4'h0 : bit_cnt_reg + 4'h1;
      if (!ctrl_reg[CTRL_MANUAL])
        slip_cnt_reg <= 4'h0;
    end
  end

  // FIFO pointers and read pacing.
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      wptr_reg     <= '0;
      rptr_reg     <= '0;
      clk_prev_reg <= 1'b0;
      pop_reg      <= 1'b0;
    end
    else
    begin
      clk_prev_reg <= pin_ok[1];
      pop_reg      <= pop;
      if (push)
        wptr_reg <= wptr_reg + PW'(1);
      if (pop)
        rptr_reg <= rptr_reg + PW'(1);
    end
  end

  rxcl_mem #(
    .W  (WORD_W),
    .AW (FIFO_AW)
  ) u_mem (
    .clk_sys_i (clk_sys_i),
    .we_i      (push),
    .waddr_i   (wptr_reg[FIFO_AW-1:0]),
    .wdata_i   ({pin_ok[0], shift_reg[WORD_W-1:1]}),
    .re_i      (pop),
    .raddr_i   (rptr_reg[FIFO_AW-1:0]),
    .rdata_o   (mem_rdata)
  );

  // *****************************************************
  // Output flops
  // *****************************************************
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      freq_locked_o    <= 1'b0;
      signal_detect_o  <= 1'b0;
      slip_count_out_o <= 4'h0;
      fifo_error_o     <= 1'b1;
      rec_clk_o        <= 1'b0;
      rx_word_o        <= '0;
      rx_word_valid_o  <= 1'b0;
    end
    else
    begin
      freq_locked_o    <= lk.ltd;
      signal_detect_o  <= sd_raw_reg && sd_allowed;
      slip_count_out_o <= slip_cnt_reg;
      fifo_error_o     <= fifo_full || fifo_empty;
      rx_word_valid_o  <= pop_reg;
      if (pop_reg)
        rx_word_o <= mem_rdata;
      if (!ctrl_reg[CTRL_ETH])
        rec_clk_o <= 1'b0;
      else if (!slip_now &&
               (bit_cnt_reg == HALF_BIT || bit_cnt_reg == SLIP_LAST))
        rec_clk_o <= !rec_clk_o;
    end
  end

  // ***********************************************
  // Checks
  // ***********************************************
  AST_FIFO_ERR: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (fifo_full || fifo_empty) |=> fifo_error_o)
    else $error("FIFO error missing while full or empty.");
  AST_SLIP_RANGE: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    slip_count_out_o <= SLIP_LAST)
    else $error("Slip count left the range zero to nine.");
  AST_SLIP_STEP: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    slip_now |=> slip_cnt_reg != $past(slip_cnt_reg) ##1
    slip_count_out_o == slip_cnt_reg)
    else $error("A slip did not advance the reported count.");
  AST_LOCK_OUT: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    ##1 freq_locked_o == $past(lk.ltd))
    else $error("Frequency lock output disagrees with lock state.");
  AST_LTD_FORCE: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    ctrl_reg[CTRL_LTD] |-> ##2 freq_locked_o)
    else $error("Lock-to-data control did not reach the lock output.");
  AST_REF_HOLD: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (ctrl_reg[CTRL_LOCK_REF] && !ctrl_reg[CTRL_LTD]) [*2] |=> !freq_locked_o)
    else $error("Manual reference lock showed a data lock.");
  AST_SD_GATE: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    !sd_allowed |=> !signal_detect_o)
    else $error("Signal detect present outside its modes.");
  AST_REC_ETH: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    !ctrl_reg[CTRL_ETH] |=> !rec_clk_o)
    else $error("Recovered clock runs outside Ethernet mode.");
endmodule

// [sim/rxcl_fabric_model.sv]
`timescale 1ns/100ps

// Fabric side: paces the FIFO reads and resyncs the lock level.
module rxcl_fabric_model
(
  // Clock and pacing control.
  input  wire logic clk_sys_i,
  input  wire logic run_i,
  input  wire logic locked_i,
  // Toward the block and the bench.
  output logic      rd_clk_o,
  output logic      locked_o
);
  logic [1:0] div_reg;
  logic [1:0] sync_reg;

  // Read clock at a quarter rate, parked low while stopped.
  always_ff @(posedge clk_sys_i)
  begin
    div_reg <= run_i ? div_reg + 2'h1 : 2'h0;
  end
  assign rd_clk_o = div_reg[1];

  // Two stages keep a metastable lock level out of fabric logic.
  always_ff @(posedge clk_sys_i)
  begin
    sync_reg <= {sync_reg[0], locked_i};
  end
  assign locked_o = sync_reg[1];
endmodule

// [sim/tb.sv]
`timescale 1ns/100ps

module tb;
  import rxcl_pkg::*;
  logic clk_sys_i = 1'b0, rst_i = 1'b1, rx_serial_i = 1'b0;
  logic line_on = 1'b0, run = 1'b0, lk_sync, rx_coreclk_i;
  logic freq_locked_o, signal_detect_o, fifo_error_o, rec_clk_o;
  logic rx_word_valid_o, s_axi_awready_o, s_axi_wready_o;
  logic s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
  logic s_axi_awvalid_i = 1'b0, s_axi_wvalid_i = 1'b0;
  logic s_axi_bready_i = 1'b0, s_axi_arvalid_i = 1'b0;
  logic s_axi_rready_i = 1'b0;
  logic [3:0]  slip_count_out_o, s_axi_wstrb_i = 4'hf;
  logic [1:0]  s_axi_bresp_o, s_axi_rresp_o;
  logic [7:0]  s_axi_awaddr_i = 8'h00, s_axi_araddr_i = 8'h00;
  logic [31:0] s_axi_wdata_i = 32'h0, s_axi_rdata_o;
  logic [31:0] seed = 32'he240_dcd4;
  logic [9:0]  rx_word_o;
  logic        ph = 1'b0;
  logic [33:0] e_q[$];
  logic [31:0] m_q[$];
  string       n_q[$];
  int          errors = 0, checked = 0, words = 0, hi = 0, snap;
  int          lo = 0, nz = 0, snap_lo;

  rxcl_top #(.SD_WIN(8)) rxcl_top_i (.clk_sys_i, .rst_i, .rx_serial_i,
    .rx_coreclk_i, .freq_locked_o, .signal_detect_o, .slip_count_out_o,
    .fifo_error_o, .rec_clk_o, .rx_word_o, .rx_word_valid_o,
    .s_axi_awaddr_i, .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wdata_i,
    .s_axi_wstrb_i, .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bresp_o,
    .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_araddr_i, .s_axi_arvalid_i,
    .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rresp_o, .s_axi_rvalid_o,
    .s_axi_rready_i);
  rxcl_fabric_model rxcl_fabric_model_i (.clk_sys_i, .run_i(run),
    .locked_i(freq_locked_o), .rd_clk_o(rx_coreclk_i), .locked_o(lk_sync));

  always #2 clk_sys_i = ~clk_sys_i;

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task chk(input logic [33:0] s, input logic [33:0] e, input string n);
    checked++;
    if (s !== e)
    begin
      errors++;
      $display("BAD %s exp %h seen %h", n, e, s);
    end
  endtask

  // Each line bit lasts two cycles so the pin filter passes every change.
  always @(posedge clk_sys_i)
  begin
    seed <= lfsr(seed);
    ph <= ~ph;
    if (ph)
      rx_serial_i <= line_on & (rx_serial_i ^ ~&seed[3:0]);
  end

  // Counts words and clock highs, and compares each read answer.
  always @(posedge clk_sys_i)
  begin
    words <= words + int'(rx_word_valid_o === 1'b1);
    hi <= hi + int'(rec_clk_o === 1'b1);
    lo <= lo + int'(fifo_error_o === 1'b0);
    nz <= nz + int'(rx_word_valid_o === 1'b1 && rx_word_o != 10'h0);
    if (rx_word_valid_o === 1'b1 && !line_on)
      chk(rx_word_o, 10'h0, "word_idle");
    if (s_axi_rvalid_o === 1'b1 && s_axi_rready_i)
      chk({s_axi_rresp_o, s_axi_rdata_o & m_q.pop_front()},
          e_q.pop_front(), n_q.pop_front());
  end

  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    @(posedge clk_sys_i);
    s_axi_awaddr_i <= a;
    s_axi_wdata_i <= d;
    s_axi_awvalid_i <= 1'b1;
    s_axi_wvalid_i <= 1'b1;
    s_axi_bready_i <= 1'b1;
    fork
      begin
        do @(posedge clk_sys_i); while (s_axi_awready_o !== 1'b1);
        s_axi_awvalid_i <= 1'b0;
      end
      begin
        do @(posedge clk_sys_i); while (s_axi_wready_o !== 1'b1);
        s_axi_wvalid_i <= 1'b0;
      end
    join
    do @(posedge clk_sys_i); while (s_axi_bvalid_o !== 1'b1);
    s_axi_bready_i <= 1'b0;
    chk({32'h0, s_axi_bresp_o}, {32'h0, r}, "bresp");
  endtask

  task rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m,
          input logic [1:0] r, input string n);
    @(posedge clk_sys_i);
    e_q.push_back({r, e});
    m_q.push_back(m);
    n_q.push_back(n);
    s_axi_araddr_i <= a;
    s_axi_arvalid_i <= 1'b1;
    s_axi_rready_i <= 1'b1;
    do @(posedge clk_sys_i); while (s_axi_arready_o !== 1'b1);
    s_axi_arvalid_i <= 1'b0;
    do @(posedge clk_sys_i); while (s_axi_rvalid_o !== 1'b1);
    s_axi_rready_i <= 1'b0;
  endtask

  task wt(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask

  task summarize;
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Whole run needs about 1200 cycles; this allows over ten times that.
  initial
  begin
    #60000;
    errors++;
    summarize;
  end

  initial
  begin
    wt(10);
    rst_i <= 1'b0;
    rd(ADDR_CTRL, 32'h0, 32'hffff_ffff, RESP_OKAY, "ctrl");
    rd(ADDR_THRESH, 32'h4, 32'hffff_ffff, RESP_OKAY, "thresh");
    rd(ADDR_STATUS, 32'h4, 32'h7, RESP_OKAY, "status");
    rd(8'h10, 32'h0, 32'hffff_ffff, RESP_SLVERR, "unmapped");
    wr(8'h10, 32'h1, RESP_SLVERR);
    for (int k = 0; k < 4; k++)
    begin
      wr(ADDR_CTRL, k, RESP_OKAY);
      wt(6);
      chk(lk_sync, k[0], "lock");
      rd(ADDR_STATUS, {22'h0, k[0] ? 2'h2 : {1'b0, k[1]}, 7'h0, k[0]},
         32'h301, RESP_OKAY, "mode");
    end
    wr(ADDR_CTRL, 32'h5, RESP_OKAY);
    for (int i = 1; i <= 10; i++)
    begin
      wr(ADDR_SLIP, 32'h1, RESP_OKAY);
      wt(4);
      chk(slip_count_out_o, i % 10, "slip");
    end
    line_on <= 1'b1;
    wr(ADDR_THRESH, 32'h0, RESP_OKAY);
    wr(ADDR_CTRL, 32'h9, RESP_OKAY);
    snap = hi;
    wt(80);
    chk(signal_detect_o, 1'b0, "sd_mode");
    chk(hi != snap, 1'b1, "rclk_on");
    wr(ADDR_CTRL, 32'h11, RESP_OKAY);
    wt(80);
    chk(signal_detect_o, 1'b1, "sd_basic");
    snap = hi;
    wt(40);
    chk(hi == snap, 1'b1, "rclk_off");
    wr(ADDR_THRESH, 32'hff, RESP_OKAY);
    wt(80);
    chk(signal_detect_o, 1'b0, "sd_thresh");
    wr(ADDR_CTRL, 32'h21, RESP_OKAY);
    wr(ADDR_THRESH, 32'h0, RESP_OKAY);
    wt(80);
    chk(signal_detect_o, 1'b1, "sd_pipe");
    wr(ADDR_CTRL, 32'h41, RESP_OKAY);
    wt(150);
    chk(fifo_error_o, 1'b1, "fifo_full");
    snap = words;
    snap_lo = lo;
    run <= 1'b1;
    wt(200);
    chk(words != snap, 1'b1, "rd_clk");
    chk(lo != snap_lo, 1'b1, "fifo_level");
    chk(nz != 0, 1'b1, "word_data");
    wr(ADDR_CTRL, 32'h2, RESP_OKAY);
    wr(ADDR_CTRL, 32'h0, RESP_OKAY);
    wt(6);
    chk(lk_sync, 1'b0, "auto_wait");
    wt(300);
    chk(lk_sync, 1'b1, "auto_lock");
    summarize;
  end
endmodule
